// ---- hdl/sscd_pkg.sv ----
/*
 constants, command and diagnosis codes and carrier types for the
 switch serial command and diagnosis block.
 assumes nothing of its surroundings.
*/
package sscd_pkg;
	// ==========================================================
	// frame layout
	localparam int FRAME_W = 16;
	// ==========================================================
	// control byte: operation nibble and group nibble
	localparam logic [3:0] NIB_DIAG = 4'h0;
	localparam logic [3:0] NIB_READ = 4'hC;
	localparam logic [3:0] NIB_ECHO = 4'hA;
	localparam logic [3:0] NIB_OR = 4'h3;
	localparam logic [3:0] NIB_AND = 4'hF;
	localparam logic [3:0] GRP_LO = 4'h0;
	localparam logic [3:0] GRP_HI = 4'hF;
	// ==========================================================
	// two-bit diagnosis codes per channel
	localparam logic [1:0] DG_OK = 2'h3;
	localparam logic [1:0] DG_ILIM = 2'h2;
	localparam logic [1:0] DG_OPEN = 2'h1;
	localparam logic [1:0] DG_SGND = 2'h0;
	// ==========================================================
	// combining modes and reset values
	localparam logic MODE_OR = 1'b0;
	localparam logic MODE_AND = 1'b1;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [15:0] TX_RST = 16'h0000;
	localparam logic [15:0] OFF_RST = 16'h0000;
	localparam logic [2:0] CS_IDLE = 3'h7;
	localparam logic [7:0] PAR_RST = 8'h00;
	// ==========================================================
	// types
	typedef enum logic [2:0] {
		CMD_DIAG = 3'b000,
		CMD_READ = 3'b001,
		CMD_ECHO = 3'b010,
		CMD_OR = 3'b011,
		CMD_AND = 3'b100,
		CMD_BAD = 3'b101
	} sscd_cmd_t;
	typedef struct packed {
		logic [3:0] op;
		logic [3:0] grp;
		logic [7:0] data;
	} sscd_frame_t;
	typedef struct packed {
		logic [15:0] ilim;
		logic [15:0] open_ld;
		logic [15:0] sgnd;
	} sscd_fault_t;
endpackage

// ---- hdl/sscd_core.sv ----
/*
 serial command decoder and diagnosis feedback of a sixteen channel
 low-side switch: frame shifting on the serial clock, decode, output
 combining and diagnosis latching on the system clock.
 assumes the host keeps sclk idle while cs_n is high and leaves cs_n
 high for at least four system clocks between frames.
*/
`timescale 1ns/10ps

// Overview of operation
// - read-back puts the eight parallel input levels on the first eight out bits.
// - read-back last eight bits are per-channel flags, high means no fault.
// - echo command loops serial in to serial out for one next frame only.
// - echo changes no state; afterwards the returned word is all zeros.
// - OR command, low group: channels 1-4 are input OR data bit.
// - OR command, high group: channels 9-12 are input OR data bit.
// - combining mode is OR after reset.
// - combining mode stays latched until the opposite command arrives.
// - AND command, low group: channels 1-4 are input AND data bit.
// - AND command, high group: channels 9-12 are input AND data bit.
// - unknown control words are ignored and the next returned word is zero.
// - full diagnosis gives two bits per channel, HH meaning no fault.
// - current limiting active reads HL.
// - open load reads LH.
// - drain short to ground reads LL.
// - diagnosis of the last read group clears at the falling chip select.
// - OR and AND commands return the group's full diagnosis next frame.
// - low control nibble all low selects channels 1-8, all high 9-16.
// - serial in sampled on falling sclk, frame taken at rising chip select.
// - serial out floats while deselected, MSB first, changes after rising sclk.
// - each accepted data bit switches its channel on when high, except in AND mode while that channel's input is low.
module sscd_core import sscd_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	input wire logic par_input_ch1,
	input wire logic par_input_ch2,
	input wire logic par_input_ch3,
	input wire logic par_input_ch4,
	input wire logic par_input_ch9,
	input wire logic par_input_ch10,
	input wire logic par_input_ch11,
	input wire logic par_input_ch12,
	input wire sscd_fault_t fault_i,
	output logic so_o,
	output logic so_oe,
	output logic [15:0] ch_on,
	output logic [1:0] and_mode
);
	logic [15:0] rx_sr_r;
	logic [3:0] tx_idx_r;
	logic tx_go_r;
	logic [2:0] cs_s_r;
	logic [7:0] par_pins;
	logic [7:0] par_s1_r;
	logic [7:0] par_s2_r;
	sscd_fault_t flt_s1_r;
	sscd_fault_t flt_s2_r;
	logic frame_end;
	logic frame_start;
	logic exec;
	sscd_frame_t fr;
	sscd_cmd_t cmd;
	logic grp;
	logic echo_r;
	logic [15:0] tx_word_r;
	logic [15:0] data_r;
	logic [1:0] mode_r;
	logic [15:0][1:0] diag_r;
	logic [15:0][1:0] live;
	logic [7:0][1:0] diag_grp;
	logic [7:0] flags;
	logic clr_pend_r;
	logic clr_grp_r;
	logic [15:0] out_c;
	logic [15:0] ch_on_r;

	// ==========================================================
	// link side, clocked by sclk
	// only the last sixteen bits shifted in count as the frame
	always_ff @(negedge sclk) begin
		rx_sr_r <= {rx_sr_r[14:0], si};
	end

	// cs_n high ends the frame; the clock may stop right after
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			tx_go_r <= 1'b0;
			tx_idx_r <= 4'h0;
		end else begin
			tx_go_r <= 1'b1;
			if (tx_go_r) begin
				tx_idx_r <= tx_idx_r + 4'h1;
			end
		end
	end

	// tx_word_r and echo_r only change while cs_n is high
	always_comb begin
		so_oe = ~cs_n;
		so_o = echo_r ? si : tx_word_r[~tx_idx_r];
	end

	// ==========================================================
	// synchronisers into the system clock
	assign par_pins = {par_input_ch12, par_input_ch11, par_input_ch10,
		par_input_ch9, par_input_ch4, par_input_ch3, par_input_ch2,
		par_input_ch1};

	always_ff @(posedge clock) begin
		if (rst) begin
			cs_s_r <= CS_IDLE;
		end else begin
			cs_s_r <= {cs_s_r[1:0], cs_n};
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			par_s1_r <= PAR_RST;
			par_s2_r <= PAR_RST;
			flt_s1_r <= '0;
			flt_s2_r <= '0;
		end else begin
			par_s1_r <= par_pins;
			par_s2_r <= par_s1_r;
			flt_s1_r <= fault_i;
			flt_s2_r <= flt_s1_r;
		end
	end

	assign frame_end = cs_s_r[1] & ~cs_s_r[2];
	assign frame_start = ~cs_s_r[1] & cs_s_r[2];
	// a frame clocked during echo is looped back, never executed
	assign exec = frame_end & ~echo_r;

	// ==========================================================
	// decode; rx_sr_r is quiet here because sclk idles
	assign fr = sscd_frame_t'(rx_sr_r);
	assign grp = (fr.grp == GRP_HI);

	always_comb begin
		cmd = CMD_BAD;
		if (fr.grp == GRP_LO || fr.grp == GRP_HI) begin
			case (fr.op)
				NIB_DIAG: begin
					cmd = CMD_DIAG;
				end
				NIB_READ: begin
					cmd = CMD_READ;
				end
				NIB_ECHO: begin
					cmd = CMD_ECHO;
				end
				NIB_OR: begin
					cmd = CMD_OR;
				end
				NIB_AND: begin
					cmd = CMD_AND;
				end
				default: begin
					cmd = CMD_BAD;
				end
			endcase
		end
	end

	// ==========================================================
	// latched command state
	always_ff @(posedge clock) begin
		if (rst) begin
			echo_r <= 1'b0;
		end else if (frame_end) begin
			echo_r <= ~echo_r & (cmd == CMD_ECHO);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			mode_r <= MODE_RST;
		end else if (exec && cmd == CMD_OR) begin
			mode_r[grp] <= MODE_OR;
		end else if (exec && cmd == CMD_AND) begin
			mode_r[grp] <= MODE_AND;
		end
	end

	// other commands ignore the data byte
	always_ff @(posedge clock) begin
		if (rst) begin
			data_r <= OFF_RST;
		end else if (exec && (cmd == CMD_OR || cmd == CMD_AND)) begin
			if (grp) begin
				data_r[15:8] <= fr.data;
			end else begin
				data_r[7:0] <= fr.data;
			end
		end
	end

	// ==========================================================
	// diagnosis
	// current limit outranks short to ground, which outranks open load
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (flt_s2_r.ilim[i]) begin
				live[i] = DG_ILIM;
			end else if (flt_s2_r.sgnd[i]) begin
				live[i] = DG_SGND;
			end else if (flt_s2_r.open_ld[i]) begin
				live[i] = DG_OPEN;
			end else begin
				live[i] = DG_OK;
			end
		end
	end

	// a fault present at the clear is kept: set wins
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < 16; i++) begin
				diag_r[i] <= DG_OK;
			end
		end else begin
			for (int i = 0; i < 16; i++) begin
				if (live[i] != DG_OK || (frame_start && clr_pend_r &&
					((i >= 8) == clr_grp_r))) begin
					diag_r[i] <= live[i];
				end
			end
		end
	end

	assign diag_grp = grp ? diag_r[15:8] : diag_r[7:0];

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			flags[i] = (diag_grp[i] == DG_OK);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			clr_pend_r <= 1'b0;
			clr_grp_r <= 1'b0;
		end else if (frame_start) begin
			clr_pend_r <= 1'b0;
		end else if (exec && cmd != CMD_BAD && cmd != CMD_ECHO) begin
			clr_pend_r <= 1'b1;
			clr_grp_r <= grp;
		end
	end

	// ==========================================================
	// word returned in the next frame
	always_ff @(posedge clock) begin
		if (rst) begin
			tx_word_r <= TX_RST;
		end else if (frame_end) begin
			if (echo_r) begin
				tx_word_r <= TX_RST;
			end else begin
				case (cmd)
					CMD_DIAG, CMD_OR, CMD_AND: begin
						tx_word_r <= diag_grp;
					end
					CMD_READ: begin
						tx_word_r <= {par_s2_r, flags};
					end
					default: begin
						tx_word_r <= TX_RST;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// output combining; re-evaluated every clock for pwm inputs
	always_comb begin
		out_c = data_r;
		for (int k = 0; k < 4; k++) begin
			out_c[k] = mode_r[0] ? (data_r[k] & par_s2_r[k]) :
				(data_r[k] | par_s2_r[k]);
			out_c[k + 8] = mode_r[1] ? (data_r[k + 8] & par_s2_r[k + 4]) :
				(data_r[k + 8] | par_s2_r[k + 4]);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ch_on_r <= OFF_RST;
		end else begin
			ch_on_r <= out_c;
		end
	end

	assign ch_on = ch_on_r;
	assign and_mode = mode_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence s_echo_cmd;
		exec && cmd == CMD_ECHO;
	endsequence
	sequence s_echo_end;
		frame_end && echo_r;
	endsequence

	a_echo_open: assert property (
		s_echo_cmd |=> echo_r ##1 echo_r)
		else $error("echo loop not closed");
	a_echo_once: assert property (
		s_echo_end |=> !echo_r && tx_word_r == TX_RST)
		else $error("echo loop not reopened with zero word");
	a_echo_still: assert property (
		(s_echo_cmd or s_echo_end) |=> $stable(data_r) && $stable(mode_r))
		else $error("echo changed state");
	a_read_word: assert property (
		exec && cmd == CMD_READ |=>
		tx_word_r == {$past(par_s2_r), $past(flags)})
		else $error("read-back word wrong");
	a_full_diag: assert property (
		exec && (cmd == CMD_OR || cmd == CMD_AND || cmd == CMD_DIAG) |=>
		tx_word_r == $past(diag_grp))
		else $error("full diagnosis word wrong");
	a_or_combine: assert property (
		1'b1 |=> ($past(mode_r[0]) || ch_on_r[3:0] ==
		($past(data_r[3:0]) | $past(par_s2_r[3:0]))) &&
		($past(mode_r[1]) || ch_on_r[11:8] ==
		($past(data_r[11:8]) | $past(par_s2_r[7:4]))))
		else $error("or combining wrong");
	a_and_combine: assert property (
		1'b1 |=> (!$past(mode_r[0]) || ch_on_r[3:0] ==
		($past(data_r[3:0]) & $past(par_s2_r[3:0]))) &&
		(!$past(mode_r[1]) || ch_on_r[11:8] ==
		($past(data_r[11:8]) & $past(par_s2_r[7:4]))))
		else $error("and combining wrong");
	a_mode_reset: assert property (
		$fell(rst) |-> mode_r == MODE_RST)
		else $error("mode not or after reset");
	a_mode_latch: assert property (
		!(exec && (cmd == CMD_OR || cmd == CMD_AND)) |=> $stable(mode_r))
		else $error("mode changed without command");
	a_bad_clear: assert property (
		exec && cmd == CMD_BAD |=> tx_word_r == TX_RST && $stable(data_r))
		else $error("unknown command not ignored");
	a_ilim_code: assert property (
		flt_s2_r.ilim[0] |=> diag_r[0] == DG_ILIM)
		else $error("current limit code missing");
	a_solo_chan: assert property (
		1'b1 |=> ch_on_r[7:4] == $past(data_r[7:4]) &&
		ch_on_r[15:12] == $past(data_r[15:12]))
		else $error("serial-only channel wrong");
endmodule

// ---- dv/sscd_host.sv ----
/*
 host model: serial master that shifts one sixteen bit frame out and
 captures the returned word, sclk idle low, one bit every 160 ns.
 assumes the bench calls xfer from one process at a time.
*/
`timescale 1ns/10ps
module sscd_host (
	output logic sclk,
	output logic cs_n,
	output logic si,
	input wire logic so_o,
	input wire logic so_oe
);
	// ==========================================================
	// idle state
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// ==========================================================
	// one frame; a deselected so reads as z so a float is never a match
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		cs_n = 1'b0;
		// si moves just after the rising edge, half a period before the
		// falling edge that samples it; so is taken before sclk falls
		for (int i = 15; i >= 0; i--) begin
			#80 sclk = 1'b1;
			si = w[i];
			#80 r[i] = so_oe ? so_o : 1'bz;
			sclk = 1'b0;
		end
		#80 cs_n = 1'b1;
		// released line must not keep the last bit
		si = ~si;
		// gap well above four clocks; frames may repeat back to back
		#300;
	endtask
endmodule

// ---- dv/sscd_tb.sv ----
/*
 self-checking bench for the serial command and diagnosis block.
 assumes the host model drives the serial side and the bench the rest.
*/
`timescale 1ns/10ps
module sscd_tb
	import sscd_pkg::*;
;
	logic clock, rst, sclk, cs_n, si, so_o, so_oe;
	logic [3:0] pl, ph;
	sscd_fault_t flt;
	logic [15:0] ch_on, exp_on, r;
	logic [1:0] and_mode, m;
	int bad_count, n_checks, cyc;
	sscd_core dut (.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n),
		.si(si), .par_input_ch1(pl[0]), .par_input_ch2(pl[1]),
		.par_input_ch3(pl[2]), .par_input_ch4(pl[3]),
		.par_input_ch9(ph[0]), .par_input_ch10(ph[1]),
		.par_input_ch11(ph[2]), .par_input_ch12(ph[3]), .fault_i(flt),
		.so_o(so_o), .so_oe(so_oe), .ch_on(ch_on), .and_mode(and_mode));
	sscd_host host (.sclk(sclk), .cs_n(cs_n), .si(si), .so_o(so_o),
		.so_oe(so_oe));
	// ==========================================================
	// clock, timeout, verdict
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			close_out();
		end
	end
	task automatic close_out();
		if (bad_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask
	function automatic logic [7:0] comb(logic md, logic [7:0] d,
		logic [3:0] p);
		return md ? {d[7:4], d[3:0] & p} : {d[7:4], d[3:0] | p};
	endfunction
	task automatic set_flt(input logic [15:0] il, op, sg);
		@(posedge clock);
		flt <= '{ilim: il, open_ld: op, sgnd: sg};
		repeat (5) @(posedge clock);
		// back off the clock edge so serial events never meet it
		#3;
	endtask
	// ==========================================================
	// accepted control frame, updates the expected outputs
	task automatic ctl(input logic [15:0] w);
		logic md;
		md = (w[15:12] == NIB_AND);
		host.xfer(w, r);
		m[w[8]] = md;
		if (w[8])
			exp_on[15:8] = comb(md, w[7:0], ph);
		else
			exp_on[7:0] = comb(md, w[7:0], pl);
		chk("ch_on", exp_on, ch_on);
		chk("and_mode", {14'h0, m}, {14'h0, and_mode});
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset();
		chk("ch_on", {4'h0, ph, 4'h0, pl}, ch_on);
		chk("and_mode", 16'h0000, {14'h0, and_mode});
		chk("so_oe", 16'h0000, {15'h0, so_oe});
	endtask
	task automatic t_combine();
		logic [15:0] cmds [4];
		cmds = '{16'hFF5A, 16'h3089, 16'hF00F, 16'h3F3C};
		for (int k = 0; k < 4; k++)
			ctl(cmds[k]);
	endtask
	task automatic t_diag();
		set_flt(16'h0001, 16'h0002, 16'h0004);
		ctl(16'h3089);
		// settle time, then the identical frame returns the diagnosis
		#150000;
		ctl(16'h3089);
		chk("diag settled", 16'hFFC6, r);
		set_flt(16'h0000, 16'h0000, 16'h0000);
		host.xfer(16'h0000, r);
		chk("diag", 16'hFFC6, r);
		host.xfer(16'h0000, r);
		chk("diag cleared", 16'hFFFF, r);
		chk("ch_on", exp_on, ch_on);
	endtask
	task automatic t_read();
		set_flt(16'h0010, 16'h0000, 16'h0000);
		host.xfer(16'hC0FF, r);
		host.xfer(16'h70F0, r);
		chk("read back", {ph, pl, 8'hEF}, r);
		chk("ch_on", exp_on, ch_on);
		host.xfer(16'h0000, r);
		chk("after bad", TX_RST, r);
		set_flt(16'h0000, 16'h0000, 16'h0000);
	endtask
	task automatic t_echo();
		host.xfer(16'hA000, r);
		host.xfer(16'h1234, r);
		chk("echo", 16'h1234, r);
		host.xfer(16'h0000, r);
		chk("after echo", TX_RST, r);
		chk("ch_on", exp_on, ch_on);
		chk("and_mode", {14'h0, m}, {14'h0, and_mode});
	endtask
	// ==========================================================
	// main sequence
	initial begin
		rst = 1'b1;
		pl = 4'b0101;
		ph = 4'b0011;
		flt = '0;
		exp_on = {4'h0, ph, 4'h0, pl};
		m = MODE_RST;
		bad_count = 0;
		n_checks = 0;
		cyc = 0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		repeat (6) @(posedge clock);
		// keep the serial side out of phase with the system clock
		#3;
		t_reset();
		t_combine();
		t_diag();
		t_read();
		t_echo();
		close_out();
	end
endmodule
